// ==== pppoe_agent_regs.vh ====
`ifndef PPPOE_AGENT_REGS_VH
`define PPPOE_AGENT_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL     8'h00
`define OFS_SLOT     8'h04
`define OFS_PORTIDX  8'h08
`define OFS_VLAN     8'h0c
`define OFS_MAC_LO   8'h10
`define OFS_MAC_HI   8'h14
`define OFS_LENS     8'h18
`define OFS_STRWR    8'h1c
`define OFS_STAT     8'h20
`define OFS_INFO     8'h24
// ----------------------------------------
// control bits and reset values
// ----------------------------------------
`define CTRL_GLOBAL  0
`define CTRL_PORT    1
`define CTRL_TRUST   2
`define CTRL_STRIP   3
`define CTRL_RST     4'h0
`define SLOT_RST     16'h3031
`define PORT_RST     24'h303031
`define VLAN_RST     32'h30303031
`define SEL_ANI      2'h0
`define SEL_CID      2'h1
`define SEL_RID      2'h2
// ----------------------------------------
// frame layout and protocol values
// ----------------------------------------
`define ET_DISC      16'h8863
`define ET_SESS      16'h8864
`define VER_TYPE     8'h11
`define CODE_INIT    8'h09
`define CODE_OFFER   8'h07
`define CODE_REQ     8'h19
`define CODE_CONF    8'h65
`define CODE_TERM    8'ha7
`define TAG_END      16'h0000
`define TAG_SVC      16'h0101
`define TAG_SRV      16'h0102
`define TAG_HOST     16'h0103
`define TAG_COOKIE   16'h0104
`define TAG_VENDOR   16'h0105
`define TAG_RELAY    16'h0110
`define TAG_ESVC     16'h0201
`define TAG_ESRV     16'h0202
`define TAG_EGEN     16'h0203
`define SUB_CIRCUIT  8'h01
`define SUB_REMOTE   8'h02
`define HDR_LEN      11'd20
`define FCS_LEN      11'd4
`define MAC_LEN      8'd6
`define CID_FIXED    8'd16
`define CRC_INIT     32'hffffffff
`define CRC_POLY     32'hedb88320
`define CH_SPACE     8'h20
`define CH_SLASH     8'h2f
`define CH_COLON     8'h3a
`define CH_ETH       24'h657468
`endif

// ==== pppoe_discovery_tag_agent.v ====
`timescale 1ns/10ps
`include "pppoe_agent_regs.vh"
module pppoe_discovery_tag_agent #(
  parameter        MAXLEN    = 1536,
  parameter [31:0] VENDOR_ID = 32'h00005a5a // arbitrary value
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [7:0]  inData,
  input  wire        inValid,
  input  wire        inLast,
  output reg         inReady,
  output reg  [7:0]  outData,
  output reg         outValid,
  output reg         outLast,
  input  wire        outReady
);
  localparam [1:0] RECV = 2'd0;
  localparam [1:0] SCAN = 2'd1;
  localparam [1:0] SEND = 2'd2;
  localparam [1:0] FCS  = 2'd3;
  localparam [10:0] MAXP = MAXLEN - 1;
  localparam [15:0] VTAG = `TAG_VENDOR; // split into bytes by the tag builder
  localparam [23:0] ETHS = `CH_ETH;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rstQ1, rstSyncB;
  // async assert, clocked release so no flop leaves reset on a runt edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstQ1    <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstQ1    <= 1'b1;
      rstSyncB <= rstQ1;
    end
  end

  // ----------------------------------------
  // configuration and bus slave
  // ----------------------------------------
  reg  [3:0]  ctrl_reg;
  reg  [15:0] slot_reg;
  reg  [23:0] portIdx_reg;
  reg  [31:0] vlan_reg;
  reg  [47:0] mac_reg;
  reg  [5:0]  aniLen_reg;
  reg  [6:0]  cidLen_reg;
  reg  [5:0]  ridLen_reg;
  reg         wrPend;
  reg  [7:0]  wrAddr;
  reg  [7:0]  aniMem [0:46];
  reg  [7:0]  cidMem [0:127];
  reg  [7:0]  ridMem [0:62];
  reg  [15:0] dropCnt_reg, insCnt_reg;
  reg  [8:0]  seen_reg;
  reg  [7:0]  lastCode_reg;
  reg  [1:0]  state_reg;
  reg  [31:0] rdMux;
  wire        addrPh = hready & hsel & htrans[1];

  // read data is prepared in the address phase: zero wait states
  always @* begin
    rdMux = 32'h00000000;
    if (haddr[7:0] == `OFS_CTRL) rdMux = {28'h0000000, ctrl_reg};
    else if (haddr[7:0] == `OFS_SLOT) rdMux = {16'h0000, slot_reg};
    else if (haddr[7:0] == `OFS_PORTIDX) rdMux = {8'h00, portIdx_reg};
    else if (haddr[7:0] == `OFS_VLAN) rdMux = vlan_reg;
    else if (haddr[7:0] == `OFS_MAC_LO) rdMux = mac_reg[31:0];
    else if (haddr[7:0] == `OFS_MAC_HI) rdMux = {16'h0000, mac_reg[47:32]};
    else if (haddr[7:0] == `OFS_LENS)
      rdMux = {10'h000, ridLen_reg, 1'b0, cidLen_reg, 2'h0, aniLen_reg};
    else if (haddr[7:0] == `OFS_STAT) rdMux = {insCnt_reg, dropCnt_reg};
    else if (haddr[7:0] == `OFS_INFO)
      rdMux = {5'h00, seen_reg, 6'h00, state_reg, 2'h0, lastCode_reg};
  end

  // writes land one cycle after the address phase, as the data arrives
  always @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      wrPend      <= 1'b0;
      wrAddr      <= 8'h00;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      ctrl_reg    <= `CTRL_RST;
      slot_reg    <= `SLOT_RST;
      portIdx_reg <= `PORT_RST;
      vlan_reg    <= `VLAN_RST;
      mac_reg     <= 48'h000000000000;
      aniLen_reg  <= 6'h00;
      cidLen_reg  <= 7'h00;
      ridLen_reg  <= 6'h00;
    end else begin
      wrPend <= addrPh & hwrite;
      wrAddr <= haddr[7:0];
      if (addrPh & ~hwrite)
        hrdata <= rdMux;
      if (wrPend) begin
        if (wrAddr == `OFS_CTRL) ctrl_reg <= hwdata[3:0];
        else if (wrAddr == `OFS_SLOT) slot_reg <= hwdata[15:0];
        else if (wrAddr == `OFS_PORTIDX) portIdx_reg <= hwdata[23:0];
        else if (wrAddr == `OFS_VLAN) vlan_reg <= hwdata;
        else if (wrAddr == `OFS_MAC_LO) mac_reg[31:0] <= hwdata;
        else if (wrAddr == `OFS_MAC_HI) mac_reg[47:32] <= hwdata[15:0];
        else if (wrAddr == `OFS_LENS) begin
          aniLen_reg <= (hwdata[5:0] > 6'd46) ? 6'd46 : hwdata[5:0];
          cidLen_reg <= hwdata[14:8];
          ridLen_reg <= (hwdata[21:16] > 6'd62) ? 6'd62 : hwdata[21:16];
        end
      end
    end
  end

  // string bytes: {sel, index, byte}; no reset, contents are data
  always @(posedge clk) begin
    if (wrPend && wrAddr == `OFS_STRWR) begin
      if (hwdata[17:16] == `SEL_ANI && hwdata[14:8] < 7'd47)
        aniMem[hwdata[13:8]] <= hwdata[7:0];
      else if (hwdata[17:16] == `SEL_CID)
        cidMem[hwdata[14:8]] <= hwdata[7:0];
      else if (hwdata[17:16] == `SEL_RID && hwdata[14:8] < 7'd63)
        ridMem[hwdata[13:8]] <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // frame store and field view
  // ----------------------------------------
  reg  [7:0]  mem [0:MAXLEN-1];
  reg  [10:0] wrPtr, scanPos, rdPos, nextTag;
  reg  [15:0] stripSum;
  reg  [7:0]  insIdx;
  reg  [2:0]  fcsIdx;
  reg         doIns, doStrip;
  reg  [31:0] crc;
  wire [10:0] curPos   = (state_reg == SCAN) ? scanPos : rdPos;
  wire [15:0] tagT     = {mem[curPos], mem[curPos + 11'd1]};
  wire [15:0] tagL     = {mem[curPos + 11'd2], mem[curPos + 11'd3]};
  wire [15:0] ethType  = {mem[12], mem[13]};
  wire [7:0]  code     = mem[15];
  wire [15:0] pppLen   = {mem[18], mem[19]};
  wire [10:0] frameLen = wrPtr - `FCS_LEN;
  wire [16:0] tagEnd   = {6'h00, `HDR_LEN} + {1'b0, pppLen};
  wire [16:0] tagNext  = {6'h00, curPos} + 17'd4 + {1'b0, tagL};
  wire        inTags   = {6'h00, curPos} < tagEnd && curPos + 11'd4 <= frameLen;
  wire        accept   = inValid & inReady;

  // payload bytes are kept whole; the trailing FCS is rebuilt on the way out
  always @(posedge clk) begin
    if (accept && wrPtr < MAXLEN)
      mem[wrPtr] <= inData;
  end

  // ----------------------------------------
  // vendor tag builder
  // ----------------------------------------
  wire [7:0] nodeLen = (aniLen_reg != 6'h00) ? {2'h0, aniLen_reg} : `MAC_LEN;
  wire [7:0] cLen    = (cidLen_reg != 7'h00) ? {1'b0, cidLen_reg}
                       : nodeLen + `CID_FIXED;
  wire [7:0] rLen    = (ridLen_reg != 6'h00) ? {2'h0, ridLen_reg} : `MAC_LEN;
  wire [15:0] tagDl  = {8'h00, cLen} + {8'h00, rLen} + 16'd8;
  wire [15:0] insLen = tagDl + 16'd4;
  reg  [7:0] vtByte, ci, ri, fi;

  // byte insIdx of the inserted tag, built on the fly, never stored
  always @* begin
    vtByte = 8'h00;
    ci = insIdx - 8'd10;
    ri = insIdx - 8'd12 - cLen;
    fi = ci - nodeLen;
    case (insIdx)
      8'd0: vtByte = VTAG[15:8];
      8'd1: vtByte = VTAG[7:0];
      8'd2: vtByte = tagDl[15:8];
      8'd3: vtByte = tagDl[7:0];
      8'd4: vtByte = VENDOR_ID[31:24];
      8'd5: vtByte = VENDOR_ID[23:16];
      8'd6: vtByte = VENDOR_ID[15:8];
      8'd7: vtByte = VENDOR_ID[7:0];
      8'd8: vtByte = `SUB_CIRCUIT;
      8'd9: vtByte = cLen;
      default: begin
        if (insIdx == cLen + 8'd10) vtByte = `SUB_REMOTE;
        else if (insIdx == cLen + 8'd11) vtByte = rLen;
        else if (insIdx > cLen + 8'd11) begin
          if (ridLen_reg != 6'h00) vtByte = ridMem[ri[5:0]];
          else vtByte = mac_reg[47 - 8 * ri[2:0] -: 8];
        end else if (cidLen_reg != 7'h00) vtByte = cidMem[ci[6:0]];
        else if (ci < nodeLen) begin
          if (aniLen_reg != 6'h00) vtByte = aniMem[ci[5:0]];
          else vtByte = mac_reg[47 - 8 * ci[2:0] -: 8];
        end else begin
          case (fi)
            8'd0, 8'd4: vtByte = `CH_SPACE;
            8'd1: vtByte = ETHS[23:16];
            8'd2: vtByte = ETHS[15:8];
            8'd3: vtByte = ETHS[7:0];
            8'd5: vtByte = slot_reg[15:8];
            8'd6: vtByte = slot_reg[7:0];
            8'd7: vtByte = `CH_SLASH;
            8'd8: vtByte = portIdx_reg[23:16];
            8'd9: vtByte = portIdx_reg[15:8];
            8'd10: vtByte = portIdx_reg[7:0];
            8'd11: vtByte = `CH_COLON;
            8'd12: vtByte = vlan_reg[31:24];
            8'd13: vtByte = vlan_reg[23:16];
            8'd14: vtByte = vlan_reg[15:8];
            default: vtByte = vlan_reg[7:0];
          endcase
        end
      end
    endcase
  end

  // ----------------------------------------
  // admission decision
  // ----------------------------------------
  wire active  = ctrl_reg[`CTRL_GLOBAL] & ctrl_reg[`CTRL_PORT];
  wire trusted = ctrl_reg[`CTRL_TRUST];
  wire isDisc  = active && wrPtr >= 11'd24 && ethType == `ET_DISC;
  wire hdrOk   = mem[14] == `VER_TYPE;
  wire clientC = code == `CODE_INIT || code == `CODE_REQ || code == `CODE_TERM;
  wire dropIt  = isDisc && (!hdrOk || (!trusted && !clientC));
  wire insIt   = isDisc && hdrOk && (code == `CODE_INIT || code == `CODE_REQ);
  wire stripIt = isDisc && hdrOk && trusted && ctrl_reg[`CTRL_STRIP];
  wire [15:0] newLen = pppLen + (doIns ? insLen : 16'h0000)
                       - (doStrip ? stripSum : 16'h0000);

  // ----------------------------------------
  // output byte selection and crc
  // ----------------------------------------
  wire advance = ~outValid | outReady;
  wire insNow  = doIns && rdPos == `HDR_LEN && {8'h00, insIdx} < insLen;
  wire skipNow = doStrip && rdPos == nextTag && inTags && tagT == `TAG_VENDOR;
  wire [7:0] bufByte = (rdPos == 11'd18) ? newLen[15:8]
                     : (rdPos == 11'd19) ? newLen[7:0] : mem[rdPos];
  wire [7:0] emitB = insNow ? vtByte : bufByte;

  // reflected crc-32, one byte per call
  function [31:0] crcStep;
    input [31:0] c;
    input [7:0]  d;
    integer k;
    begin
      crcStep = c ^ {24'h000000, d};
      for (k = 0; k < 8; k = k + 1)
        crcStep = crcStep[0] ? ((crcStep >> 1) ^ `CRC_POLY) : (crcStep >> 1);
    end
  endfunction

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      state_reg    <= RECV;
      inReady      <= 1'b0;
      outData      <= 8'h00;
      outValid     <= 1'b0;
      outLast      <= 1'b0;
      wrPtr        <= 11'h000;
      scanPos      <= 11'h000;
      rdPos        <= 11'h000;
      nextTag      <= 11'h000;
      stripSum     <= 16'h0000;
      insIdx       <= 8'h00;
      fcsIdx       <= 3'h0;
      doIns        <= 1'b0;
      doStrip      <= 1'b0;
      crc          <= `CRC_INIT;
      dropCnt_reg  <= 16'h0000;
      insCnt_reg   <= 16'h0000;
      seen_reg     <= 9'h000;
      lastCode_reg <= 8'h00;
    end else begin
      case (state_reg)
        RECV: begin
          inReady <= 1'b1;
          if (accept) begin
            if (wrPtr != MAXP) wrPtr <= wrPtr + 11'd1; // long frames truncate
            if (inLast) begin
              inReady   <= 1'b0;
              state_reg <= SCAN;
              scanPos   <= `HDR_LEN;
              stripSum  <= 16'h0000;
              seen_reg  <= 9'h000;
            end
          end
        end
        // walk the tag list once to learn how many bytes a strip removes
        SCAN: begin
          if (isDisc && inTags && tagT != `TAG_END) begin
            scanPos <= tagNext[10:0];
            if (tagT == `TAG_VENDOR)
              stripSum <= stripSum + 16'd4 + tagL;
            seen_reg <= seen_reg | {
              tagT == `TAG_EGEN, tagT == `TAG_ESRV, tagT == `TAG_ESVC,
              tagT == `TAG_RELAY, tagT == `TAG_COOKIE, tagT == `TAG_HOST,
              tagT == `TAG_SRV, tagT == `TAG_SVC, tagT == `TAG_VENDOR};
          end else begin
            lastCode_reg <= code;
            if (dropIt) begin
              dropCnt_reg <= dropCnt_reg + 16'd1;
              wrPtr       <= 11'h000;
              state_reg   <= RECV;
            end else begin
              if (insIt) insCnt_reg <= insCnt_reg + 16'd1;
              doIns     <= insIt;
              doStrip   <= stripIt;
              rdPos     <= 11'h000;
              nextTag   <= `HDR_LEN;
              insIdx    <= 8'h00;
              crc       <= `CRC_INIT;
              state_reg <= SEND;
            end
          end
        end
        SEND: begin
          if (advance) begin
            if (insNow) begin
              insIdx <= insIdx + 8'd1;
            end else if (rdPos < frameLen && skipNow) begin
              rdPos   <= tagNext[10:0];
              nextTag <= tagNext[10:0];
            end else if (rdPos < frameLen) begin
              if (rdPos == nextTag && inTags) nextTag <= tagNext[10:0];
              rdPos <= rdPos + 11'd1;
            end else begin
              state_reg <= FCS;
              fcsIdx    <= 3'h0;
            end
            outValid <= insNow || (rdPos < frameLen && !skipNow);
            outData  <= emitB;
            outLast  <= 1'b0;
            if (insNow || (rdPos < frameLen && !skipNow))
              crc <= crcStep(crc, emitB);
          end
        end
        FCS: begin
          if (advance) begin
            if (fcsIdx < 3'd4) begin
              outValid <= 1'b1;
              outData  <= ~crc[8 * fcsIdx[1:0] +: 8];
              outLast  <= fcsIdx == 3'd3;
              fcsIdx   <= fcsIdx + 3'd1;
            end else begin
              outValid  <= 1'b0;
              outLast   <= 1'b0;
              wrPtr     <= 11'h000;
              state_reg <= RECV;
            end
          end
        end
        default: state_reg <= RECV;
      endcase
    end
  end
endmodule // pppoe_discovery_tag_agent

// ==== pppoe_agent_asserts.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// stream and bus checker
// ----------------------------------------
module pppoe_agent_asserts (
  input wire        clk,
  input wire        rst_b,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [7:0]  inData,
  input wire        inValid,
  input wire        inLast,
  input wire        inReady,
  input wire [7:0]  outData,
  input wire        outValid,
  input wire        outLast,
  input wire        outReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg  [10:0] inCnt, outCnt;
  reg  [7:0]  etHi, etLo, codeB;
  wire        inHs  = inValid && inReady;
  wire        outHs = outValid && outReady;
  // byte positions of both streams, header bytes kept for comparison
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inCnt  <= 11'h0;
      outCnt <= 11'h0;
      etHi   <= 8'h0;
      etLo   <= 8'h0;
      codeB  <= 8'h0;
    end else begin
      if (inHs) inCnt <= inLast ? 11'h0 : inCnt + 11'h1;
      if (inHs && inCnt == 11'd12) etHi <= inData;
      if (inHs && inCnt == 11'd13) etLo <= inData;
      if (inHs && inCnt == 11'd15) codeB <= inData;
      if (outHs) outCnt <= outLast ? 11'h0 : outCnt + 11'h1;
    end
  end
  property p_et_hi; outHs && outCnt == 11'd12 |-> outData == etHi; endproperty
  a_et_hi: assert property (p_et_hi) else $error("ethertype high byte altered");
  property p_et_lo; outHs && outCnt == 11'd13 |-> outData == etLo; endproperty
  a_et_lo: assert property (p_et_lo) else $error("ethertype low byte altered");
  property p_code; outHs && outCnt == 11'd15 |-> outData == codeB; endproperty
  a_code: assert property (p_code) else $error("code byte altered");
  property p_quiet; inReady |-> !outValid; endproperty
  a_quiet: assert property (p_quiet) else $error("output while still receiving");
  property p_gap; outHs && outLast |=> !outValid [*8]; endproperty
  a_gap: assert property (p_gap) else $error("output right after frame end");
  property p_hold;
    outValid && !outReady |=> outValid && $stable(outData) && $stable(outLast);
  endproperty
  a_hold: assert property (p_hold) else $error("output byte changed while stalled");
  property p_dropin; inHs && inLast |=> !inReady; endproperty
  a_dropin: assert property (p_dropin) else $error("input still ready after last byte");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus wait or error response");
  property p_unmap;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] > 8'h24 |=> hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_tag: cover property (outHs && outCnt == 11'd20 && outData == 8'h01);
  c_stall: cover property (outValid && !outReady);
  c_end: cover property (outHs && outLast);
endmodule // pppoe_agent_asserts

bind pppoe_discovery_tag_agent pppoe_agent_asserts chk_u (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .inData(inData), .inValid(inValid),
  .inLast(inLast), .inReady(inReady), .outData(outData), .outValid(outValid),
  .outLast(outLast), .outReady(outReady));

// ==== pppoe_stream_sink.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// far-side sink: collects every accepted byte
// ----------------------------------------
module pppoe_stream_sink (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [7:0] outData,
  input  wire       outValid,
  input  wire       outLast,
  input  wire       stall,
  output logic      outReady
);
  logic [7:0] got[$];
  logic [1:0] ph;
  int         lastAt = 0;
  // stalling holds ready low three cycles of four to stress the hold rule
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph       <= 2'h0;
      outReady <= 1'b0;
    end else begin
      ph       <= ph + 2'h1;
      outReady <= !stall || ph == 2'h3;
    end
  end
  // capture on handshake only
  always @(posedge clk) begin
    if (outValid && outReady) got.push_back(outData);
    if (outValid && outReady && outLast) lastAt = got.size();
  end
endmodule // pppoe_stream_sink

// ==== tb.sv ====
`timescale 1ns/10ps
`include "pppoe_agent_regs.vh"
`define CHK(n,e,g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  localparam [31:0] VID = 32'h00001234; // arbitrary value
  logic        clk = 0, rst_b = 0, hsel = 0, hwrite = 0, inValid = 0, inLast = 0, stall = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0]  htrans = 0, kind;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  inData = 0, ver, code;
  logic [15:0] et;
  logic [3:0]  ctrl;
  logic        vt;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, inReady, outValid, outLast, outReady;
  wire  [7:0]  outData;
  logic [7:0]  fin[$], exp[$], cid[$], rid[$];
  int          bad_count = 0, checks_done = 0;
  // ethertype, version byte, code, ctrl {strip,trust,port,global}, vendor tag in, outcome
  // outcome: 0 dropped, 1 unchanged, 2 tag added, 3 tag stripped
  logic [38:0] rows [0:12] = '{
    {16'h0800, 8'h11, 8'h09, 4'h3, 1'b0, 2'd1}, {16'h8864, 8'h11, 8'h09, 4'h3, 1'b0, 2'd1},
    {16'h8863, 8'h11, 8'h09, 4'h3, 1'b0, 2'd2}, {16'h8863, 8'h11, 8'h19, 4'h3, 1'b0, 2'd2},
    {16'h8863, 8'h11, 8'h07, 4'h3, 1'b0, 2'd0}, {16'h8863, 8'h11, 8'h65, 4'h3, 1'b0, 2'd0},
    {16'h8863, 8'h11, 8'ha7, 4'h3, 1'b0, 2'd1}, {16'h8863, 8'h11, 8'h65, 4'h7, 1'b0, 2'd1},
    {16'h8863, 8'h11, 8'h09, 4'h2, 1'b0, 2'd1}, {16'h8863, 8'h11, 8'h09, 4'h1, 1'b0, 2'd1},
    {16'h8863, 8'h11, 8'h07, 4'hf, 1'b1, 2'd3}, {16'h8863, 8'h11, 8'ha7, 4'hb, 1'b1, 2'd1},
    {16'h8863, 8'h22, 8'h09, 4'h3, 1'b0, 2'd0}};
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  pppoe_discovery_tag_agent #(.VENDOR_ID(VID)) dut_u (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .inData(inData), .inValid(inValid),
    .inLast(inLast), .inReady(inReady), .outData(outData), .outValid(outValid),
    .outLast(outLast), .outReady(outReady));
  pppoe_stream_sink sink_u (.clk(clk), .rst_b(rst_b), .outData(outData),
    .outValid(outValid), .outLast(outLast), .stall(stall), .outReady(outReady));
  always #5 clk = ~clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] crc(logic [7:0] q[$]);
    logic [31:0] c = 32'hffffffff;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction
  task automatic fcs(ref logic [7:0] q[$]);
    logic [31:0] c;
    c = crc(q);
    for (int k = 0; k < 4; k++) q.push_back(c[8*k +: 8]); // frame check sent low byte first
  endtask
  task automatic setlen(ref logic [7:0] q[$]);
    int n;
    n = q.size() - 20;
    q[18] = n[15:8];
    q[19] = n[7:0];
  endtask
  task automatic adds(ref logic [7:0] q[$], input string s);
    for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
  endtask
  // one single transfer, address phase then data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    @(posedge clk); while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk); while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task str(input logic [1:0] sel, input string s);
    for (int i = 0; i < s.len(); i++) ahb(1, `OFS_STRWR, {14'h0, sel, 1'b0, 7'(i), s[i]});
  endtask
  task mk(input logic [15:0] e, input logic [7:0] v, c, input logic t);
    fin = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    fin = {fin, e[15:8], e[7:0], v, c, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    if (t) fin = {fin, 8'h01, 8'h05, 8'h00, 8'h04, 8'hde, 8'had, 8'hbe, 8'hef};
    setlen(fin);
  endtask
  task mkexp(input logic [1:0] k);
    logic [7:0] t[$];
    exp = fin;
    if (k == 2'd3) repeat (8) exp.delete(24);
    if (k == 2'd2) begin
      t = {8'h01, 8'h05, 8'h00, 8'h00, VID[31:24], VID[23:16], VID[15:8], VID[7:0], 8'h01};
      t = {t, 8'(cid.size()), cid, 8'h02, 8'(rid.size()), rid};
      t[3] = 8'(t.size() - 4);
      exp = {exp[0:19], t, exp[20:$]};
    end
    setlen(exp);
    fcs(exp);
    if (k == 2'd0) exp.delete();
  endtask
  // send one frame with its check bytes, wait until the agent is idle again
  task run(input string nm);
    logic [7:0] q[$];
    int n;
    sink_u.got.delete();
    sink_u.lastAt = 0;
    q = fin;
    fcs(q);
    foreach (q[i]) begin
      inData <= q[i]; inValid <= 1; inLast <= (i == q.size() - 1);
      @(posedge clk); while (inReady !== 1'b1) @(posedge clk);
    end
    inValid <= 0; inLast <= 0; n = 0;
    @(posedge clk);
    while (inReady !== 1'b1 && n < 800) begin @(posedge clk); n++; end
    if (n >= 800) begin
      bad_count++;
      end_sim;
    end
    `CHK("frame size", exp.size(), sink_u.got.size())
    `CHK("last flag", exp.size(), sink_u.lastAt)
    foreach (exp[i]) `CHK("frame byte", exp[i], sink_u.got[i])
    $display("test %s done", nm);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  // hang guard, well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    repeat (6) @(posedge clk);
    ahb(0, `OFS_CTRL, 0); `CHK("ctrl reset", 32'h0, rd)
    ahb(0, `OFS_SLOT, 0); `CHK("slot reset", 32'h00003031, rd)
    ahb(0, 8'h40, 0); `CHK("unmapped read", 32'h0, rd)
    $display("test reset done");
    ahb(1, `OFS_MAC_LO, 32'h0c0d0e0f);
    ahb(1, `OFS_MAC_HI, 32'h00000a0b);
    cid = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
    rid = cid;
    adds(cid, " eth 01/001:0001");
    for (int i = 0; i < 13; i++) begin
      {et, ver, code, ctrl, vt, kind} = rows[i];
      ahb(1, `OFS_CTRL, {28'h0, ctrl});
      mk(et, ver, code, vt);
      mkexp(kind);
      run("row");
    end
    // configured node id and remote id, far side stalling
    ahb(1, `OFS_CTRL, 32'h3);
    str(2'h0, "abcd");
    str(2'h2, "xyz");
    ahb(1, `OFS_LENS, 32'h00030004);
    cid.delete(); adds(cid, "abcd eth 01/001:0001");
    rid.delete(); adds(rid, "xyz");
    stall <= 1;
    mk(16'h8863, 8'h11, 8'h09, 1'b0); mkexp(2'd2);
    run("node and remote id");
    // per-port circuit id replaces the default one
    str(2'h1, "bbbb");
    ahb(1, `OFS_LENS, 32'h00030404);
    cid.delete(); adds(cid, "bbbb");
    mk(16'h8863, 8'h11, 8'h19, 1'b0); mkexp(2'd2);
    run("port circuit id");
    // counters: rows 2, 3 and the two hand tests insert; rows 4, 5, 12 drop
    ahb(0, `OFS_STAT, 0); `CHK("frame counters", 32'h00040003, rd)
    // last frame was a request carrying one service-name tag, agent idle
    ahb(0, `OFS_INFO, 0); `CHK("last frame info", 32'h00080019, rd)
    $display("test status done");
    // second reset while idle: control, lengths and counters return to zero
    rst_b <= 0;
    repeat (4) @(posedge clk);
    rst_b <= 1;
    repeat (6) @(posedge clk);
    ahb(0, `OFS_CTRL, 0); `CHK("ctrl after reset", 32'h0, rd)
    ahb(0, `OFS_STAT, 0); `CHK("counters after reset", 32'h0, rd)
    ahb(0, `OFS_LENS, 0); `CHK("lens after reset", 32'h0, rd)
    $display("test second reset done");
    end_sim;
  end
endmodule // tb
